/* core/dslim_top.sv */
// Four-channel digital slew limiter with an AXI4-Lite register slave and clear input.
//
// Function
// R01 - Slew limiting acts on a channel only while its enable is set.
// R02 - With limiting off, the new code reaches the converter at once.
// R03 - With limiting on, the applied code changes only on update ticks.
// R04 - Each tick moves the applied code by the selected step toward target.
// R05 - Four-bit rate code picks 64 kHz down to 0.5 Hz ticks.
// R06 - Three-bit step code picks 1, 2, 4, 16, 32, 64, 128 or 256 LSBs.
// R07 - Update ticks are divided down from the internal clock, not the serial clock.
// R08 - While limiting is on, every output change passes through the stepping.
// R09 - Clear on an allowed, slew-enabled channel steps toward its clear code.
// R10 - Host takes care clearing several slew channels; some may jump directly.
// R11 - Tick rate for a code is the same for every output range.
// R12 - Step sizes count code LSBs, whatever the output range.
// R13 - Slew limiting serves both current and voltage outputs.
// R14 - Clear acts only on channels whose clear allow is set.
// R15 - Clear is active high, edge sensitive; cleared code holds until rewritten.
// R16 - When remaining distance is below the step, land exactly on target.
// R17 - Each channel keeps its own applied code, target and divider phase.
module dslim_top
    import dslim_pkg::*;
(
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data.
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response.
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read.
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Clear pin, asynchronous to aclk.
    input  wire logic        clear_in,
    // Converter side.
    output logic [dslim_pkg::NUM_CH-1:0][dslim_pkg::CODE_W-1:0] dac_code,
    output logic [dslim_pkg::NUM_CH-1:0]                      slewing
);
    import dslim_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic                                 aw_ok;
        logic [7:0]                           aw_addr;
        logic                                 w_ok;
        logic [31:0]                          w_data;
        logic [3:0]                           w_strb;
        logic                                 awready;
        logic                                 wready;
        logic                                 bvalid;
        logic [1:0]                           bresp;
        logic                                 arready;
        logic                                 rvalid;
        logic [31:0]                          rdata;
        logic [1:0]                           rresp;
        logic [NUM_CH-1:0][CODE_W-1:0]        target;
        logic [NUM_CH-1:0][CODE_W-1:0]        clr_code;
        logic [NUM_CH-1:0][CTRL_W-1:0]        ctrl;
        logic                                 clr_s1;
        logic                                 clr_s2;
        logic                                 clr_s3;
        logic [7:0]                           base_cnt;
        logic                                 base_tick;
    } dslim_state_t;

    dslim_state_t r_reg;
    dslim_state_t r_next;
    logic         clear_edge;
    logic         wr_commit;

    // Merges a written word into an old one, byte lane by byte lane.
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                res[b*8 +: 8] = new_v[b*8 +: 8];
        end
        lane_merge = res;
    endfunction

    // Addresses above the last channel are unmapped.
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = a < 8'(NUM_CH * CH_STRIDE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    assign clear_edge = r_reg.clr_s2 && !r_reg.clr_s3; // [R15]
    assign wr_commit = r_reg.aw_ok && r_reg.w_ok && !r_reg.bvalid;

    always_comb
    begin
        logic [1:0]  wch;
        logic [1:0]  rch;
        logic [31:0] old_v;
        logic [31:0] new_v;
        wch = r_reg.aw_addr[5:4];
        rch = s_axi_araddr[5:4];
        old_v = '0;
        new_v = '0;
        r_next = r_reg;

        // Clear pin synchroniser; only the second and third stages feed logic.
        r_next.clr_s1 = clear_in;
        r_next.clr_s2 = r_reg.clr_s1;
        r_next.clr_s3 = r_reg.clr_s2;

        // The base tick is the fastest update rate, divided from the core clock. [R07]
        if (r_reg.base_cnt == BASE_TICK_LAST)
        begin
            r_next.base_cnt = '0;
            r_next.base_tick = 1'b1;
        end
        else
        begin
            r_next.base_cnt = 8'(r_reg.base_cnt + 8'h01);
            r_next.base_tick = 1'b0;
        end

        // Address and data are taken independently; one write is in flight at a time.
        if (r_reg.awready && s_axi_awvalid)
        begin
            r_next.aw_ok = 1'b1;
            r_next.aw_addr = s_axi_awaddr;
            r_next.awready = 1'b0;
        end
        if (r_reg.wready && s_axi_wvalid)
        begin
            r_next.w_ok = 1'b1;
            r_next.w_data = s_axi_wdata;
            r_next.w_strb = s_axi_wstrb;
            r_next.wready = 1'b0;
        end

        if (wr_commit)
        begin
            r_next.aw_ok = 1'b0;
            r_next.w_ok = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = addr_hit(r_reg.aw_addr) ? RESP_OKAY : RESP_DECERR;
            if (addr_hit(r_reg.aw_addr))
            begin
                case (r_reg.aw_addr[3:0])
                    REG_TARGET:
                    begin
                        old_v = {16'h0000, r_reg.target[wch]};
                        new_v = lane_merge(old_v, r_reg.w_data, r_reg.w_strb);
                        r_next.target[wch] = new_v[15:0]; // [R08]
                    end
                    REG_CLEAR_CODE:
                    begin
                        old_v = {16'h0000, r_reg.clr_code[wch]};
                        new_v = lane_merge(old_v, r_reg.w_data, r_reg.w_strb);
                        r_next.clr_code[wch] = new_v[15:0];
                    end
                    REG_CONTROL:
                    begin
                        old_v = {23'h00_0000, r_reg.ctrl[wch]};
                        new_v = lane_merge(old_v, r_reg.w_data, r_reg.w_strb);
                        r_next.ctrl[wch] = new_v[CTRL_W-1:0];
                    end
                    default:
                    begin
                        // Status is read only; the write is accepted and dropped.
                        old_v = '0;
                    end
                endcase
            end
        end

        // A clear edge loads the clear code as the new target of allowed channels.
        // It is applied after a register write in the same cycle, so the clear wins.
        if (clear_edge)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (r_reg.ctrl[c][CTRL_CLR_BIT]) // [R14]
                    r_next.target[c] = r_reg.clr_code[c]; // [R09] [R15]
            end
        end

        if (r_reg.bvalid && s_axi_bready)
        begin
            r_next.bvalid = 1'b0;
            r_next.awready = 1'b1;
            r_next.wready = 1'b1;
        end

        // Reads answer one cycle after the address is taken.
        if (r_reg.arready && s_axi_arvalid)
        begin
            r_next.arready = 1'b0;
            r_next.rvalid = 1'b1;
            r_next.rresp = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
            r_next.rdata = '0;
            if (addr_hit(s_axi_araddr))
            begin
                case (s_axi_araddr[3:0])
                    REG_TARGET:     r_next.rdata = {16'h0000, r_reg.target[rch]};
                    REG_CLEAR_CODE: r_next.rdata = {16'h0000, r_reg.clr_code[rch]};
                    REG_CONTROL:    r_next.rdata = {23'h00_0000, r_reg.ctrl[rch]};
                    REG_STATUS:     r_next.rdata = {15'h0000, slewing[rch], dac_code[rch]};
                    default:        r_next.rdata = '0;
                endcase
            end
        end
        if (r_reg.rvalid && s_axi_rready)
        begin
            r_next.rvalid = 1'b0;
            r_next.arready = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_reg <= '0;
            r_reg.awready <= 1'b1;
            r_reg.wready <= 1'b1;
            r_reg.arready <= 1'b1;
            for (int c = 0; c < NUM_CH; c++)
            begin
                r_reg.target[c] <= TARGET_RESET;
                r_reg.clr_code[c] <= CLEAR_CODE_RESET;
                r_reg.ctrl[c] <= CTRL_RESET;
            end
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign s_axi_awready = r_reg.awready;
    assign s_axi_wready = r_reg.wready;
    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_arready = r_reg.arready;
    assign s_axi_rvalid = r_reg.rvalid;
    assign s_axi_rdata = r_reg.rdata;
    assign s_axi_rresp = r_reg.rresp;

    ////////////////////////////////////////////////////////////////////////////
    // Channels: each keeps its own divider phase and applied code.

    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        dslim_chan u_chan (
            .aclk                  (aclk),
            .aresetn               (aresetn),
            .base_tick             (r_reg.base_tick),
            .slew_limit_enable     (r_reg.ctrl[c][CTRL_EN_BIT]),
            .slew_tick_rate_select (r_reg.ctrl[c][CTRL_RATE_LSB +: 4]),
            .slew_step_size_select (r_reg.ctrl[c][CTRL_STEP_LSB +: 3]), // [R06]
            .target_code           (r_reg.target[c]),
            .applied_code          (dac_code[c]),
            .slewing               (slewing[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_base_tick_gap: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
        r_reg.base_tick |=> !r_reg.base_tick [*8])
        else $error("Base tick fired faster than its divider allows.");

    a_clear_loads: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
        clear_edge && r_reg.ctrl[0][CTRL_CLR_BIT] |=> r_reg.target[0] == $past(r_reg.clr_code[0]))
        else $error("Clear edge did not load the clear code on an allowed channel.");

    a_clear_keeps: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
        clear_edge && !r_reg.ctrl[1][CTRL_CLR_BIT] && !wr_commit |=> $stable(r_reg.target[1]))
        else $error("Clear changed a channel that is not allowed to clear.");

    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_commit |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("Write response did not follow the committed write.");

endmodule

/* core/dslim_pkg.sv */
// Package with register map, field layout and timing constants of the digital slew limiter.
package dslim_pkg;

    localparam int NUM_CH = 4;
    localparam int CODE_W = 16;
    localparam int PHASE_W = 17;

    // Register map: byte address = channel * 0x10 + register offset.
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [3:0] REG_TARGET = 4'h0;
    localparam logic [3:0] REG_CLEAR_CODE = 4'h4;
    localparam logic [3:0] REG_CONTROL = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;

    // Control register fields.
    localparam int CTRL_W = 9;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RATE_LSB = 1;
    localparam int CTRL_STEP_LSB = 5;
    localparam int CTRL_CLR_BIT = 8;
    localparam logic [8:0] CTRL_RESET = 9'h000;

    // Status register fields.
    localparam int STAT_BUSY_BIT = 16;

    // Reset values of the code registers.
    localparam logic [15:0] TARGET_RESET = 16'h0000;
    localparam logic [15:0] CLEAR_CODE_RESET = 16'h0000;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Timing: the fastest update rate is the base tick; slower rates divide it.
    localparam longint CLK_HZ = 10_000_000;
    localparam longint BASE_TICK_HZ = 64_000;
    localparam int BASE_TICK_CYC = int'(CLK_HZ / BASE_TICK_HZ);
    localparam logic [7:0] BASE_TICK_LAST = 8'(BASE_TICK_CYC - 1);

    // Step size in LSBs for a step select code.
    function automatic logic [8:0] step_lsb(input logic [2:0] sel);
        case (sel)
            3'h0:    step_lsb = 9'h001;
            3'h1:    step_lsb = 9'h002;
            3'h2:    step_lsb = 9'h004;
            3'h3:    step_lsb = 9'h010;
            3'h4:    step_lsb = 9'h020;
            3'h5:    step_lsb = 9'h040;
            3'h6:    step_lsb = 9'h080;
            default: step_lsb = 9'h100;
        endcase
    endfunction

    // Last phase count of the per-channel divider for a rate select code.
    // The slow codes divide by decimal counts so that 64 Hz down to 0.5 Hz stay exact.
    function automatic logic [16:0] rate_last(input logic [3:0] sel);
        case (sel)
            4'ha:    rate_last = 17'h0_03e7;
            4'hb:    rate_last = 17'h0_07cf;
            4'hc:    rate_last = 17'h0_0f9f;
            4'hd:    rate_last = 17'h0_1f3f;
            4'he:    rate_last = 17'h0_3e7f;
            4'hf:    rate_last = 17'h1_f3ff;
            default: rate_last = 17'((17'h0_0001 << sel) - 17'h0_0001);
        endcase
    endfunction

endpackage

/* core/dslim_chan.sv */
// One channel of the slew limiter: tick divider and stepping of the applied code.
module dslim_chan
    import dslim_pkg::*;
(
    // Clock and reset.
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // Settings and target.
    input  wire logic                       base_tick,
    input  wire logic                       slew_limit_enable,
    input  wire logic [3:0]                 slew_tick_rate_select,
    input  wire logic [2:0]                 slew_step_size_select,
    input  wire logic [dslim_pkg::CODE_W-1:0] target_code,
    // Result.
    output logic      [dslim_pkg::CODE_W-1:0] applied_code,
    output logic                            slewing
);
    import dslim_pkg::*;

    typedef struct packed {
        logic [CODE_W-1:0]  applied;
        logic [PHASE_W-1:0] phase;
        logic               busy;
    } dslim_chan_t;

    dslim_chan_t r_reg;
    dslim_chan_t r_next;
    logic              tick;
    logic [8:0]        step;
    logic [CODE_W-1:0] diff;

    assign step = step_lsb(slew_step_size_select);
    // The update tick depends only on the rate code, never on the output range. [R11] [R05]
    assign tick = base_tick && (r_reg.phase >= rate_last(slew_tick_rate_select));
    assign diff = (target_code > r_reg.applied) ? 16'(target_code - r_reg.applied)
                                                : 16'(r_reg.applied - target_code);

    always_comb
    begin
        r_next = r_reg;
        if (!slew_limit_enable)
        begin
            r_next.applied = target_code; // [R01] [R02]
            r_next.phase = '0;
        end
        else
        begin
            if (base_tick)
                r_next.phase = tick ? '0 : 17'(r_reg.phase + 17'h0_0001); // [R17]
            // Steps are counted in code LSBs for every output range and mode. [R12] [R13]
            if (tick && diff != '0) // [R03] [R08]
            begin
                if ({7'h00, step} >= diff)
                    r_next.applied = target_code; // [R16]
                else if (target_code > r_reg.applied)
                    r_next.applied = 16'(r_reg.applied + {7'h00, step}); // [R04]
                else
                    r_next.applied = 16'(r_reg.applied - {7'h00, step}); // [R04]
            end
        end
        r_next.busy = slew_limit_enable && (r_next.applied != target_code);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign applied_code = r_reg.applied;
    assign slewing = r_reg.busy;

    a_pass_through: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
        !slew_limit_enable |=> applied_code == $past(target_code))
        else $error("Disabled channel did not pass the target straight through.");

    a_hold_no_tick: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
        slew_limit_enable && !tick |=> $stable(applied_code))
        else $error("Applied code changed without an update tick.");

    a_step_amount: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
        slew_limit_enable && tick && {7'h00, step} < diff && target_code > applied_code
        |=> applied_code == 16'($past(applied_code) + {7'h00, $past(step)}))
        else $error("Upward step was not the selected step size.");

    a_no_overshoot: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
        slew_limit_enable && tick && {7'h00, step} >= diff
        |=> applied_code == $past(target_code))
        else $error("Final step did not land exactly on the target.");

endmodule

/* dv/tb.sv */
// Self-checking testbench of the four-channel digital slew limiter.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dslim_pkg::*;

    localparam int STEPS [8] = '{1, 2, 4, 16, 32, 64, 128, 256};
    localparam int TIMEOUT_CYC = 20000;

    logic                                 aclk = 1'b0;
    logic                                 aresetn = 1'b0;
    logic                                 s_axi_awvalid = 1'b0;
    logic                                 s_axi_awready;
    logic [7:0]                           s_axi_awaddr = 8'h00;
    logic                                 s_axi_wvalid = 1'b0;
    logic                                 s_axi_wready;
    logic [31:0]                          s_axi_wdata = 32'h0000_0000;
    logic [3:0]                           s_axi_wstrb = 4'hf;
    logic                                 s_axi_bvalid;
    logic                                 s_axi_bready = 1'b0;
    logic [1:0]                           s_axi_bresp;
    logic                                 s_axi_arvalid = 1'b0;
    logic                                 s_axi_arready;
    logic [7:0]                           s_axi_araddr = 8'h00;
    logic                                 s_axi_rvalid;
    logic                                 s_axi_rready = 1'b0;
    logic [31:0]                          s_axi_rdata;
    logic [1:0]                           s_axi_rresp;
    logic                                 clear_in = 1'b0;
    logic [NUM_CH-1:0][CODE_W-1:0]        dac_code;
    logic [NUM_CH-1:0]                    slewing;
    int                                   error_cnt = 0;
    int                                   n_tests = 0;
    int                                   cyc_cnt = 0;

    dslim_top i_dut (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awprot  (3'h0),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arprot  (3'h0),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .clear_in      (clear_in),
        .dac_code      (dac_code),
        .slewing       (slewing)
    );

    always #50 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A hung handshake never returns, so the cycle ceiling ends the run instead.
    always @(posedge aclk)
    begin
        cyc_cnt++;
        if (cyc_cnt == TIMEOUT_CYC)
        begin
            error_cnt++;
            final_report();
        end
    end

    function automatic logic [7:0] reg_addr(input int ch, input logic [3:0] off);
        return 8'(ch * CH_STRIDE) + {4'h0, off};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= addr;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= data;
        s_axi_bready  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1)
            begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1)
            begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= addr;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Write that is expected to be accepted.
    task automatic wr(input int ch, input logic [3:0] off, input logic [31:0] data);
        logic [1:0] resp;
        axi_write(reg_addr(ch, off), data, resp);
        check(32'(resp), 32'(RESP_OKAY));
    endtask

    task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp, input logic [1:0] exp_resp);
        logic [31:0] data;
        logic [1:0]  resp;
        axi_read(addr, data, resp);
        check(data, exp);
        check(32'(resp), 32'(exp_resp));
    endtask

    // Returns the number of edges until the applied code of a channel moves.
    task automatic wait_change(input int ch, output int cyc);
        logic [CODE_W-1:0] old;
        old = dac_code[ch];
        cyc = 0;
        while (dac_code[ch] === old)
        begin
            @(posedge aclk);
            cyc++;
        end
    endtask

    function automatic logic [31:0] ctrl(input bit en, input int rate, input int st, input bit clr);
        return (32'(en) << CTRL_EN_BIT) | (32'(rate) << CTRL_RATE_LSB) | (32'(st) << CTRL_STEP_LSB)
               | (32'(clr) << CTRL_CLR_BIT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int cyc;
        int cur;
        int tgt;
        logic [1:0] resp;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd_check(reg_addr(2, REG_CONTROL), 32'h0000_0000, RESP_OKAY);
        rd_check(reg_addr(2, REG_STATUS), 32'h0000_0000, RESP_OKAY);
        // Limiting off: the code goes straight through.
        wr(0, REG_TARGET, 32'h0000_1234);
        repeat (3) @(posedge aclk);
        check(32'(dac_code[0]), 32'h0000_1234);
        check(32'(slewing[0]), 32'h0000_0000);
        // Every step code at the fastest rate, upward, landing without overshoot.
        wr(2, REG_CONTROL, ctrl(1, 0, 0, 0));
        rd_check(reg_addr(2, REG_CONTROL), 32'h0000_0001, RESP_OKAY);
        cur = 0;
        for (int s = 0; s < 8; s++)
        begin
            tgt = cur + 2 * STEPS[s] - 1;
            wr(2, REG_CONTROL, ctrl(1, 0, s, 0));
            wr(2, REG_TARGET, 32'(tgt));
            wait_change(2, cyc);
            check(32'(dac_code[2]), 32'(cur + STEPS[s]));
            if (STEPS[s] > 1)
            begin
                check(32'(slewing[2]), 32'h0000_0001);
                wait_change(2, cyc);
                check(32'(dac_code[2]), 32'(tgt));
                check(32'(cyc), 32'(BASE_TICK_CYC));
            end
            repeat (2) @(posedge aclk);
            check(32'(slewing[2]), 32'h0000_0000);
            cur = tgt;
        end
        rd_check(reg_addr(2, REG_STATUS), 32'(cur), RESP_OKAY);
        // Downward at rate code 1, while channel 1 climbs at rate code 2.
        wr(1, REG_CONTROL, ctrl(1, 2, 0, 0));
        wr(1, REG_TARGET, 32'h0000_0003);
        wr(2, REG_CONTROL, ctrl(1, 1, 7, 0));
        wr(2, REG_TARGET, 32'h0000_0000);
        wait_change(2, cyc);
        check(32'(dac_code[2]), 32'(cur - 256));
        wait_change(2, cyc);
        check(32'(dac_code[2]), 32'(cur - 512));
        check(32'(cyc), 32'(2 * BASE_TICK_CYC));
        check(32'(dac_code[0]), 32'h0000_1234);
        wait_change(1, cyc);
        tgt = dac_code[1];
        wait_change(1, cyc);
        check(32'(dac_code[1]), 32'(tgt + 1));
        check(32'(cyc), 32'(4 * BASE_TICK_CYC));
        // Read-only and unmapped places.
        axi_write(reg_addr(2, REG_STATUS), 32'h0000_ffff, resp);
        check(32'(resp), 32'(RESP_OKAY));
        axi_write(8'h40, 32'h0000_0001, resp);
        check(32'(resp), 32'(RESP_DECERR));
        rd_check(8'h44, 32'h0000_0000, RESP_DECERR);
        // Clear: channel 0 jumps, channel 1 is not allowed, channel 3 slews.
        wr(0, REG_CLEAR_CODE, 32'h0000_0abc);
        wr(0, REG_CONTROL, ctrl(0, 0, 0, 1));
        wr(1, REG_CLEAR_CODE, 32'h0000_0555);
        wr(3, REG_CLEAR_CODE, 32'h0000_0020);
        wr(3, REG_CONTROL, ctrl(1, 0, 3, 1));
        // Clear is raised only once no channel is mid-slew, so none can jump past its limiter.
        while (slewing !== '0)
            @(posedge aclk);
        @(posedge aclk);
        clear_in <= 1'b1;
        repeat (10) @(posedge aclk);
        check(32'(dac_code[0]), 32'h0000_0abc);
        check(32'(dac_code[1]), 32'h0000_0003);
        check(32'(dac_code[3]), 32'h0000_0000);
        wait_change(3, cyc);
        check(32'(dac_code[3]), 32'h0000_0010);
        wait_change(3, cyc);
        check(32'(dac_code[3]), 32'h0000_0020);
        // The pin still high must not override a fresh write.
        wr(0, REG_TARGET, 32'h0000_0777);
        repeat (5) @(posedge aclk);
        check(32'(dac_code[0]), 32'h0000_0777);
        clear_in <= 1'b0;
        repeat (20) @(posedge aclk);
        check(32'(dac_code[0]), 32'h0000_0777);
        check(32'(dac_code[3]), 32'h0000_0020);
        final_report();
    end
endmodule
